// file: hdl/scd_decoder.sv
`timescale 1ns/1ps
module scd_decoder
  import scd_pkg::*;
#(
  parameter int BANK_W = BA_W,
  parameter int ROW_W = ADDR_W,
  parameter int COL_W = 10
)
(
  input wire logic clk,
  scd_if.dev bus,
  output logic cmd_valid,
  output scd_cmd_type cmd,
  output logic [BANK_W-1:0] cmd_bank,
  output logic [ROW_W-1:0] cmd_addr,
  output logic cmd_auto_precharge,
  output logic cmd_chop,
  output logic [MR_SEL_W-1:0] cmd_mr_sel,
  output scd_state_type dev_state,
  output logic dev_idle,
  output logic burst_busy,
  output logic cal_initial,
  output logic cmd_illegal
);
  // Column field must fit below A10 and be at least 3 bits wide.
  if (BANK_W < MR_SEL_W || BANK_W > BA_W || ROW_W <= A12_BIT || ROW_W > ADDR_W ||
      COL_W < 3 || COL_W > A10_BIT)
  begin : g_bad_widths
    $error("scd_decoder: unsupported field widths");
  end

  typedef struct packed {
    logic cke_prev;
    logic valid;
    scd_cmd_type cmd;
    logic [BANK_W-1:0] bank;
    logic [ROW_W-1:0] addr;
    logic ap;
    logic chop;
    logic [MR_SEL_W-1:0] mr_sel;
    scd_state_type state;
    logic [NUM_BANKS-1:0] open;
    logic [3:0] burst_cnt;
    logic [1:0] bl_mode;
    logic init_done;
    logic illegal;
  } scd_dev_type;

  scd_dev_type cur_ff;
  scd_dev_type nxt_ff;
  logic sr_exit_async;

  // Strobe decode, used for both enable-high and transition cycles.
  function automatic scd_cmd_type strobe_decode(input logic ras, input logic cas,
    input logic we, input logic a10);
    scd_cmd_type c;
    c = SCD_NONE;
    case ({ras, cas, we})
      3'h0: c = SCD_MODE_SET;
      3'h1: c = SCD_REFRESH;
      3'h2: c = a10 ? SCD_PRECHARGE_ALL : SCD_PRECHARGE;
      3'h3: c = SCD_ACTIVATE;
      3'h4: c = SCD_WRITE;
      3'h5: c = SCD_READ;
      3'h6: c = a10 ? SCD_CAL_LONG : SCD_CAL_SHORT;
      3'h7: c = SCD_NONE;
      default: c = SCD_ILLEGAL;
    endcase
    return c;
  endfunction : strobe_decode

  // The odt pin is deliberately never read here.
  always_comb
  begin
    scd_cmd_type raw;
    logic quiet;
    logic start_burst;
    raw = strobe_decode(bus.ras_n, bus.cas_n, bus.we_n, bus.addr[A10_BIT]);
    quiet = bus.cs_n || (raw == SCD_NONE);
    start_burst = 1'b0;
    nxt_ff = cur_ff;
    nxt_ff.valid = 1'b0;
    nxt_ff.cmd = SCD_NONE;
    nxt_ff.illegal = 1'b0;
    nxt_ff.cke_prev = bus.cke;
    if (cur_ff.burst_cnt != 4'h0)
    begin
      nxt_ff.burst_cnt = cur_ff.burst_cnt - 4'h1;
    end
    case ({cur_ff.cke_prev, bus.cke})
      2'b11:
      begin
        if (!quiet)
        begin
          nxt_ff.valid = 1'b1;
          nxt_ff.cmd = raw;
          nxt_ff.bank = bus.ba[BANK_W-1:0];
          nxt_ff.addr = bus.addr[ROW_W-1:0];
          nxt_ff.ap = bus.addr[A10_BIT];
          nxt_ff.mr_sel = bus.ba[MR_SEL_W-1:0];
          case (raw)
            SCD_MODE_SET:
            begin
              if (bus.ba[MR_SEL_W-1:0] == 2'h0)
                nxt_ff.bl_mode = bus.addr[1:0];
            end
            SCD_ACTIVATE:
            begin
              nxt_ff.open[bus.ba[BA_W-1:0]] = 1'b1;
              nxt_ff.state = SCD_ST_ACTIVE;
            end
            SCD_PRECHARGE:
            begin
              nxt_ff.open[bus.ba[BA_W-1:0]] = 1'b0;
            end
            SCD_PRECHARGE_ALL:
            begin
              nxt_ff.open = '0;
            end
            SCD_CAL_LONG:
            begin
              nxt_ff.init_done = 1'b1;
            end
            SCD_READ, SCD_WRITE:
            begin
              start_burst = 1'b1;
            end
            default:
            begin
              nxt_ff.illegal = (raw == SCD_ILLEGAL);
            end
          endcase
          // A burst in flight cannot be cut short, so a new one only starts when idle.
          if (start_burst && cur_ff.burst_cnt == 4'h0)
          begin
            case (cur_ff.bl_mode)
              BL_MODE_OTF: nxt_ff.chop = !bus.addr[A12_BIT];
              BL_MODE_FIXED4: nxt_ff.chop = 1'b1;
              default: nxt_ff.chop = 1'b0;
            endcase
            nxt_ff.burst_cnt = nxt_ff.chop ? 4'(BURST_CHOP_BEATS / 2) :
              4'(BURST_FULL_BEATS / 2);
            if (bus.addr[A10_BIT])
              nxt_ff.open[bus.ba[BA_W-1:0]] = 1'b0;
          end
          else if (start_burst)
          begin
            nxt_ff.illegal = 1'b1;
          end
        end
      end
      2'b10:
      begin
        if (quiet && cur_ff.burst_cnt == 4'h0)
        begin
          nxt_ff.state = (cur_ff.open != '0) ? SCD_ST_ACT_PD : SCD_ST_PRE_PD;
          nxt_ff.valid = 1'b1;
          nxt_ff.cmd = SCD_POWER_DOWN_ENTRY;
        end
        else if (!bus.cs_n && raw == SCD_REFRESH && cur_ff.open == '0 &&
                 cur_ff.burst_cnt == 4'h0)
        begin
          nxt_ff.state = SCD_ST_SELF_REFRESH;
          nxt_ff.valid = 1'b1;
          nxt_ff.cmd = SCD_SELF_REFRESH_ENTRY;
        end
        else
        begin
          nxt_ff.illegal = 1'b1;
        end
      end
      2'b01:
      begin
        if (quiet && cur_ff.state != SCD_ST_IDLE && cur_ff.state != SCD_ST_ACTIVE)
        begin
          nxt_ff.valid = 1'b1;
          nxt_ff.cmd = (cur_ff.state == SCD_ST_SELF_REFRESH) ? SCD_SELF_REFRESH_EXIT :
            SCD_POWER_DOWN_EXIT;
          nxt_ff.state = (cur_ff.open != '0) ? SCD_ST_ACTIVE : SCD_ST_IDLE;
        end
        else if (!quiet)
        begin
          nxt_ff.illegal = 1'b1;
        end
      end
      default:
      begin
        // Enable low on both edges: all inputs ignored, state and open banks held.
      end
    endcase
    if (nxt_ff.open == '0 && nxt_ff.state == SCD_ST_ACTIVE)
      nxt_ff.state = SCD_ST_IDLE;
  end

  // Exit from self refresh is a level on the enable pin, seen without the clock.
  assign sr_exit_async = bus.cke && (cur_ff.state == SCD_ST_SELF_REFRESH);

  always_ff @(posedge clk or negedge bus.reset_n)
  begin
    if (!bus.reset_n)
    begin
      cur_ff <= '{cke_prev: 1'b0, valid: 1'b0, cmd: SCD_NONE, bank: '0, addr: '0, ap: 1'b0,
        chop: 1'b0, mr_sel: '0, state: SCD_ST_PRE_PD, open: '0, burst_cnt: 4'h0,
        bl_mode: BL_MODE_FIXED8, init_done: 1'b0, illegal: 1'b0};
    end
    else
    begin
      cur_ff <= nxt_ff;
    end
  end

  assign cmd_valid = cur_ff.valid;
  assign cmd = cur_ff.cmd;
  assign cmd_bank = cur_ff.bank;
  assign cmd_addr = cur_ff.addr;
  assign cmd_auto_precharge = cur_ff.ap;
  assign cmd_chop = cur_ff.chop;
  assign cmd_mr_sel = cur_ff.mr_sel;
  assign dev_state = cur_ff.state;
  assign burst_busy = (cur_ff.burst_cnt != 4'h0);
  // Idle also requires no pending self refresh exit.
  assign dev_idle = (cur_ff.state == SCD_ST_IDLE) && !burst_busy && cur_ff.cke_prev &&
    !sr_exit_async;
  assign cal_initial = !cur_ff.init_done;
  assign cmd_illegal = cur_ff.illegal;
endmodule : scd_decoder

// file: hdl/scd_pkg.sv
package scd_pkg;
  localparam int BA_W = 3;
  localparam int ADDR_W = 14;
  localparam int A10_BIT = 10;
  localparam int A12_BIT = 12;
  localparam int NUM_BANKS = 8;
  localparam int MR_SEL_W = 2;
  localparam int BURST_CHOP_BEATS = 4;
  localparam int BURST_FULL_BEATS = 8;
  localparam logic [2:0] CYC_PER_BEAT_PAIR = 3'h1;
  localparam logic [1:0] BL_MODE_FIXED8 = 2'h0;
  localparam logic [1:0] BL_MODE_OTF = 2'h1;
  localparam logic [1:0] BL_MODE_FIXED4 = 2'h2;
  localparam logic [3:0] CKE_HOLD_CYCLES = 4'h4;

  typedef enum logic [3:0] {
    SCD_NONE, SCD_MODE_SET, SCD_REFRESH, SCD_SELF_REFRESH_ENTRY, SCD_SELF_REFRESH_EXIT,
    SCD_PRECHARGE, SCD_PRECHARGE_ALL, SCD_ACTIVATE, SCD_WRITE, SCD_READ,
    SCD_POWER_DOWN_ENTRY, SCD_POWER_DOWN_EXIT, SCD_CAL_LONG, SCD_CAL_SHORT, SCD_ILLEGAL
  } scd_cmd_type;

  typedef enum logic [2:0] {
    SCD_ST_IDLE, SCD_ST_ACTIVE, SCD_ST_ACT_PD, SCD_ST_PRE_PD, SCD_ST_SELF_REFRESH
  } scd_state_type;
endpackage : scd_pkg

// file: hdl/scd_if.sv
`timescale 1ns/1ps
interface scd_if;
  logic reset_n;
  logic cke;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic odt;
  logic [2:0] ba;
  logic [13:0] addr;
  modport dev (input reset_n, input cke, input cs_n, input ras_n, input cas_n, input we_n,
    input odt, input ba, input addr);
  modport ctl (output reset_n, output cke, output cs_n, output ras_n, output cas_n,
    output we_n, output odt, output ba, output addr);
endinterface : scd_if

// file: hdl/scd_controller.sv
`timescale 1ns/1ps
module scd_controller
  import scd_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic req_valid,
  input scd_cmd_type req_cmd,
  input wire logic [BA_W-1:0] req_bank,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic req_odt,
  output logic req_ready,
  scd_if.ctl bus
);
  typedef struct packed {
    logic rst_n;
    logic cke;
    logic [3:0] pins;
    logic odt;
    logic [BA_W-1:0] ba;
    logic [ADDR_W-1:0] addr;
    logic [3:0] hold;
    logic [3:0] burst;
  } scd_ctl_type;

  scd_ctl_type cur_ff;
  scd_ctl_type nxt_ff;

  // Accept only when enable hold time and burst have elapsed.
  assign req_ready = cur_ff.rst_n && cur_ff.hold == 4'h0 && cur_ff.burst == 4'h0;

  always_comb
  begin
    nxt_ff = cur_ff;
    nxt_ff.rst_n = 1'b1;
    // Idle cycles deselect the device; the masked strobes would read as a mode set.
    nxt_ff.pins = 4'h8;
    nxt_ff.odt = req_odt;
    nxt_ff.ba = '0;
    nxt_ff.addr = '0; // Defined levels even on don't-care pins.
    if (cur_ff.hold != 4'h0)
      nxt_ff.hold = cur_ff.hold - 4'h1;
    if (cur_ff.burst != 4'h0)
      nxt_ff.burst = cur_ff.burst - 4'h1;
    if (req_valid && req_ready)
    begin
      nxt_ff.ba = req_bank;
      nxt_ff.addr = req_addr;
      case (req_cmd)
        SCD_NONE: nxt_ff.pins = 4'h7;
        SCD_MODE_SET: nxt_ff.pins = 4'h0;
        SCD_REFRESH: nxt_ff.pins = 4'h1;
        SCD_PRECHARGE, SCD_PRECHARGE_ALL: nxt_ff.pins = 4'h2;
        SCD_ACTIVATE: nxt_ff.pins = 4'h3;
        SCD_WRITE, SCD_READ:
        begin
          nxt_ff.pins = (req_cmd == SCD_WRITE) ? 4'h4 : 4'h5;
          nxt_ff.burst = 4'(BURST_FULL_BEATS / 2);
        end
        SCD_CAL_LONG, SCD_CAL_SHORT: nxt_ff.pins = 4'h6;
        SCD_SELF_REFRESH_ENTRY:
        begin
          nxt_ff.pins = 4'h1;
          nxt_ff.cke = 1'b0;
          nxt_ff.hold = CKE_HOLD_CYCLES;
        end
        SCD_POWER_DOWN_ENTRY, SCD_POWER_DOWN_EXIT, SCD_SELF_REFRESH_EXIT:
        begin
          nxt_ff.cke = (req_cmd != SCD_POWER_DOWN_ENTRY);
          nxt_ff.hold = CKE_HOLD_CYCLES;
        end
        default: nxt_ff.pins = 4'h8;
      endcase
      if (req_cmd == SCD_PRECHARGE_ALL || req_cmd == SCD_CAL_LONG)
        nxt_ff.addr[A10_BIT] = 1'b1;
      if (req_cmd == SCD_PRECHARGE || req_cmd == SCD_CAL_SHORT)
        nxt_ff.addr[A10_BIT] = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      cur_ff <= '{rst_n: 1'b0, cke: 1'b0, pins: 4'h7, odt: 1'b0, ba: '0, addr: '0,
        hold: CKE_HOLD_CYCLES, burst: 4'h0};
    end
    else
    begin
      cur_ff <= nxt_ff;
    end
  end

  assign bus.reset_n = cur_ff.rst_n;
  assign bus.cke = cur_ff.cke;
  assign bus.cs_n = cur_ff.pins[3];
  assign bus.ras_n = cur_ff.pins[2];
  assign bus.cas_n = cur_ff.pins[1];
  assign bus.we_n = cur_ff.pins[0];
  assign bus.odt = cur_ff.odt;
  assign bus.ba = cur_ff.ba;
  assign bus.addr = cur_ff.addr;
endmodule : scd_controller

// file: sim/scd_props.sv
`timescale 1ns/1ps
module scd_props
  import scd_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic reset_n,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic cmd_valid,
  input wire scd_cmd_type cmd,
  input wire scd_state_type dev_state,
  input wire logic burst_busy,
  input wire logic cal_initial,
  input wire logic cmd_illegal
);
  logic nop;
  logic rw;
  logic ref_p;
  assign nop = cs_n | (ras_n & cas_n & we_n);
  assign rw = !cs_n & ras_n & !cas_n;
  assign ref_p = !cs_n & !ras_n & !cas_n & we_n;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset || !reset_n);
  property p_rd;
    rw && we_n && cke && $past(cke) && !burst_busy |=> cmd_valid && cmd == SCD_READ;
  endproperty
  a_rd: assert property (p_rd)
    else $error("read pattern not decoded");
  property p_nop;
    cke && $past(cke) && nop |=> !cmd_valid;
  endproperty
  a_nop: assert property (p_nop)
    else $error("idle cycle produced a command");
  property p_cke_hold;
    $changed(cke) |=> $stable(cke)[*3];
  endproperty
  a_cke_hold: assert property (p_cke_hold)
    else $error("clock enable changed too soon");
  property p_rw_space;
    rw |=> !rw[*3];
  endproperty
  a_rw_space: assert property (p_rw_space)
    else $error("burst interrupted by another access");
  property p_burst;
    cmd_valid && cmd inside {SCD_READ, SCD_WRITE} |-> burst_busy[*2];
  endproperty
  a_burst: assert property (p_burst)
    else $error("burst ended early");
  property p_cal;
    cmd_valid && cmd == SCD_CAL_LONG |=> !cal_initial;
  endproperty
  a_cal: assert property (p_cal)
    else $error("initial calibration flag stuck");
  property p_sre;
    $fell(cke) && ref_p && dev_state == SCD_ST_IDLE |=> dev_state == SCD_ST_SELF_REFRESH;
  endproperty
  a_sre: assert property (p_sre)
    else $error("self refresh not entered");
  property p_pde;
    $fell(cke) && nop && dev_state == SCD_ST_ACTIVE |=> dev_state == SCD_ST_ACT_PD;
  endproperty
  a_pde: assert property (p_pde)
    else $error("active power-down not entered");
  property p_pdx;
    $rose(cke) && nop && dev_state inside {SCD_ST_ACT_PD, SCD_ST_PRE_PD}
      |=> dev_state inside {SCD_ST_IDLE, SCD_ST_ACTIVE};
  endproperty
  a_pdx: assert property (p_pdx)
    else $error("power-down not left");
  property p_low;
    !cke && !$past(cke) |=> !cmd_valid;
  endproperty
  a_low: assert property (p_low)
    else $error("command taken with enable low");
  property p_legal;
    !cmd_illegal;
  endproperty
  a_legal: assert property (p_legal)
    else $error("illegal command combination on the pins");
endmodule : scd_props

// file: sim/test_sdram_command_decoder.sv
`timescale 1ns/1ps
module test_sdram_command_decoder
  import scd_pkg::*;
;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic req_valid = 1'b0;
  scd_cmd_type req_cmd = SCD_NONE;
  logic [BA_W-1:0] req_bank = '0;
  logic [ADDR_W-1:0] req_addr = '0;
  logic req_odt = 1'b0;
  logic req_ready, cmd_valid, cmd_ap, cmd_chop, dev_idle, burst_busy, cal_initial, cmd_illegal;
  scd_cmd_type cmd;
  scd_state_type dev_state;
  logic [2:0] cmd_bank;
  logic [13:0] cmd_addr;
  logic [1:0] cmd_mr_sel;
  int miscompares = 0;
  int n_compared = 0;
  logic [1:0] bl_mode = BL_MODE_FIXED8;
  logic [7:0] open_map = 8'h00;
  logic cke_low = 1'b1;
  logic [1:0] bl_mode_tbl [3] = '{BL_MODE_OTF, BL_MODE_FIXED4, BL_MODE_FIXED8};
  scd_if bus_if();
  scd_controller i_scd_controller (.clk(clk), .reset(reset), .req_valid(req_valid),
    .req_cmd(req_cmd), .req_bank(req_bank), .req_addr(req_addr), .req_odt(req_odt),
    .req_ready(req_ready), .bus(bus_if));
  scd_decoder i_scd_decoder (.clk(clk), .bus(bus_if), .cmd_valid(cmd_valid), .cmd(cmd),
    .cmd_bank(cmd_bank), .cmd_addr(cmd_addr), .cmd_auto_precharge(cmd_ap),
    .cmd_chop(cmd_chop), .cmd_mr_sel(cmd_mr_sel), .dev_state(dev_state),
    .dev_idle(dev_idle), .burst_busy(burst_busy), .cal_initial(cal_initial),
    .cmd_illegal(cmd_illegal));
  scd_props i_scd_props (.clk(clk), .reset(reset), .reset_n(bus_if.reset_n),
    .cke(bus_if.cke), .cs_n(bus_if.cs_n), .ras_n(bus_if.ras_n), .cas_n(bus_if.cas_n),
    .we_n(bus_if.we_n), .cmd_valid(cmd_valid), .cmd(cmd), .dev_state(dev_state),
    .burst_busy(burst_busy), .cal_initial(cal_initial), .cmd_illegal(cmd_illegal));
  always #2 clk = ~clk;

  task automatic end_sim;
    if (miscompares == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_sim

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_compared++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  // Issues one request and checks the decoded pulse one rising edge after it is taken.
  task automatic issue(input scd_cmd_type c, input logic [2:0] b, input logic [13:0] a);
    int k;
    logic ch;
    scd_state_type st;
    logic idle_exp;
    k = 0;
    @(negedge clk);
    while (req_ready !== 1'b1 && k < 64)
    begin
      @(negedge clk);
      k++;
    end
    check(req_ready, 1'b1, "ready");
    req_valid = 1'b1;
    req_cmd = c;
    req_bank = b;
    req_addr = a;
    // Termination level is random so that any influence on decoding shows up.
    req_odt = 1'($urandom);
    @(posedge clk);
    @(negedge clk);
    req_valid = 1'b0;
    @(posedge clk);
    #1;
    ch = bl_mode == BL_MODE_FIXED4 || (bl_mode == BL_MODE_OTF && !a[A12_BIT]);
    st = (|open_map) ? SCD_ST_ACTIVE : SCD_ST_IDLE;
    if (c == SCD_POWER_DOWN_ENTRY)
      st = (|open_map) ? SCD_ST_ACT_PD : SCD_ST_PRE_PD;
    if (c == SCD_SELF_REFRESH_ENTRY)
      st = SCD_ST_SELF_REFRESH;
    check(cmd_valid, c != SCD_NONE, "valid");
    check(cmd_illegal, 1'b0, "illegal");
    check(cmd, c, "cmd");
    if (c inside {SCD_READ, SCD_WRITE})
      check({cmd_bank, cmd_ap, cmd_chop}, {b, a[A10_BIT], ch}, "burst");
    if (c == SCD_MODE_SET)
      check({cmd_mr_sel, cmd_addr}, {b[1:0], a}, "mode");
    if (c == SCD_ACTIVATE)
      check({cmd_bank, cmd_addr}, {b, a}, "act");
    if (c inside {SCD_POWER_DOWN_ENTRY, SCD_POWER_DOWN_EXIT, SCD_SELF_REFRESH_ENTRY,
        SCD_SELF_REFRESH_EXIT})
      check(dev_state, st, "state");
    if (c == SCD_MODE_SET && b == 3'h0)
      bl_mode = a[1:0];
    if (c == SCD_ACTIVATE)
      open_map[b] = 1'b1;
    if (c inside {SCD_PRECHARGE, SCD_PRECHARGE_ALL})
      open_map = (c == SCD_PRECHARGE) ? open_map & ~(8'h01 << b) : 8'h00;
    if (c inside {SCD_READ, SCD_WRITE} && a[A10_BIT])
      open_map[b] = 1'b0;
    if (c inside {SCD_POWER_DOWN_ENTRY, SCD_SELF_REFRESH_ENTRY})
      cke_low = 1'b1;
    if (c inside {SCD_POWER_DOWN_EXIT, SCD_SELF_REFRESH_EXIT})
      cke_low = 1'b0;
    idle_exp = !cke_low && open_map == 8'h00 && !(c inside {SCD_READ, SCD_WRITE});
    check(dev_idle, idle_exp, "idle");
  endtask : issue

  initial
  begin
    #100000;
    miscompares++;
    end_sim();
  end

  initial
  begin
    void'($urandom(12));
    repeat (3) @(posedge clk);
    @(negedge clk);
    reset = 1'b0;
    @(negedge clk);
    check(bus_if.reset_n, 1'b1, "reset_n");
    issue(SCD_POWER_DOWN_EXIT, 3'h0, 14'h0);
    check(cal_initial, 1'b1, "cal");
    issue(SCD_CAL_LONG, 3'h0, 14'h0);
    issue(SCD_CAL_SHORT, 3'h0, 14'h0);
    issue(SCD_CAL_LONG, 3'h0, 14'h0);
    check(cal_initial, 1'b0, "cal");
    for (int m = 3; m >= 0; m--)
      issue(SCD_MODE_SET, 3'(m), {12'($urandom), BL_MODE_OTF});
    issue(SCD_REFRESH, 3'h0, 14'h0);
    issue(SCD_NONE, 3'($urandom), 14'($urandom));
    issue(SCD_ACTIVATE, 3'h5, 14'($urandom));
    // Each burst mode gets two reads and two writes, one with A12 low and one with A12 high each.
    foreach (bl_mode_tbl[i])
    begin
      issue(SCD_MODE_SET, 3'h0, {12'h0, bl_mode_tbl[i]});
      for (int w = 0; w < 4; w++)
        issue(w < 2 ? SCD_READ : SCD_WRITE, 3'h5, {1'b0, w[0], 2'h0, 10'($urandom)});
    end
    issue(SCD_READ, 3'h5, 14'h0400);
    issue(SCD_PRECHARGE_ALL, 3'h0, 14'h0400);
    issue(SCD_ACTIVATE, 3'h2, 14'($urandom));
    issue(SCD_POWER_DOWN_ENTRY, 3'h0, 14'h0);
    issue(SCD_POWER_DOWN_EXIT, 3'h0, 14'h0);
    issue(SCD_PRECHARGE, 3'h2, 14'h0);
    issue(SCD_POWER_DOWN_ENTRY, 3'h0, 14'h0);
    issue(SCD_POWER_DOWN_EXIT, 3'h0, 14'h0);
    issue(SCD_REFRESH, 3'h0, 14'h0);
    issue(SCD_SELF_REFRESH_ENTRY, 3'h0, 14'h0);
    issue(SCD_SELF_REFRESH_EXIT, 3'h0, 14'h0);
    @(negedge clk);
    reset = 1'b1;
    #1;
    check({cmd_valid, dev_state}, {1'b0, SCD_ST_PRE_PD}, "reset");
    bl_mode = BL_MODE_FIXED8;
    open_map = 8'h00;
    cke_low = 1'b1;
    repeat (3) @(negedge clk);
    reset = 1'b0;
    issue(SCD_POWER_DOWN_EXIT, 3'h0, 14'h0);
    check(cal_initial, 1'b1, "cal");
    issue(SCD_ACTIVATE, 3'h1, 14'($urandom));
    issue(SCD_READ, 3'h1, 14'h0000);
    end_sim();
  end
endmodule : test_sdram_command_decoder
